// ### page_owner_model.sv
module page_owner_model (
   // clock
   input wire logic       core_clk_i,
   // forwarded access in
   input wire logic       fwd_req_i,
   input wire logic [7:0] offset_i,
   // answer out
   output logic           ack_o,
   output logic [7:0]     rdata_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int unsigned wait_cnt;  // cycles left before the answer
   logic [7:0]  held;      // data to hand back
   initial begin
      ack_o = 1'b0;
      rdata_o = 8'h00;
      wait_cnt = 0;
   end
   // answers after one to four cycles; data toggles when not valid
   always @(posedge core_clk_i) begin
      ack_o <= 1'b0;
      rdata_o <= ~rdata_o;
      if (fwd_req_i) begin
         wait_cnt <= 1 + $urandom_range(3);
         held <= offset_i ^ 8'h5a;
      end else if (wait_cnt == 1) begin
         ack_o <= 1'b1;
         rdata_o <= held;
         wait_cnt <= 0;
      end else if (wait_cnt > 1) wait_cnt <= wait_cnt - 1;
   end
endmodule

// ### reg_addr_decoder.sv
// splits a byte address into fields and classifies the target page
module reg_addr_decoder (
   // address in
   input  wire logic [15:0] addr_i,
   input  wire logic        phy_path_i,
   // decoded fields
   output logic [3:0]       port_o,
   output logic [3:0]       page_o,
   output logic [7:0]       offset_o,
   // classification
   output logic             local_o,
   output logic             fwd_o
);

   logic legal;   // page exists in the map

   // field split, port first
   assign port_o   = addr_i[switch_regs_pkg::PORT_MSB:switch_regs_pkg::PORT_LSB];  // [R1]
   assign page_o   = addr_i[switch_regs_pkg::PAGE_MSB:switch_regs_pkg::PAGE_LSB];  // [R1]
   assign offset_o = addr_i[switch_regs_pkg::OFFS_MSB:switch_regs_pkg::OFFS_LSB];  // [R1]

   // page legality per space
   always_comb begin
      if (port_o == switch_regs_pkg::PORT_GLOBAL) begin
         legal = (page_o <= switch_regs_pkg::GPAGE_LAST);  // [R2] [R8]
      end else if (port_o <= switch_regs_pkg::PORT_LAST) begin
         legal = (page_o <= switch_regs_pkg::PPAGE_LAST)
               && (page_o != switch_regs_pkg::PPAGE_RSV_A)
               && (page_o != switch_regs_pkg::PPAGE_RSV_B);  // [R2] [R9]
      end else begin
         legal = 1'b0;  // bit 15 set: no page, access is acked with zero
      end
   end

   // phy path only ever reaches port phy pages
   always_comb begin
      if (phy_path_i) begin
         local_o = 1'b0;  // [R7]
         fwd_o   = legal && (port_o != switch_regs_pkg::PORT_GLOBAL)
                 && (page_o == switch_regs_pkg::PPAGE_PHY);  // [R7]
      end else begin
         local_o = legal && (port_o == switch_regs_pkg::PORT_GLOBAL)
                 && (page_o == switch_regs_pkg::GPAGE_OPER);  // [R6]
         fwd_o   = legal && !local_o;  // [R6]
      end
   end

endmodule

// ### switch_global_regs.sv
// Function
// R1: address split port, page, offset fields
// R2: port zero global, one to seven ports
// R3: host keeps address bit 15 zero
// R4: every register byte accessed on its own
// R5: multi-byte registers stored big-endian
// R6: spi, i2c, in-band reach all registers
// R7: phy path reaches only phy registers
// R8: global pages zero to five, rest reserved
// R9: port pages decoded, 2, 7, d-f reserved
// R10: host never writes reserved ranges
// R11: host merges reserved bits by read-or-write
// R12: sticky soft reset holds datapath, keeps registers
// R13: power event pin enable, resets off
// R14: power event pin polarity, resets low
// R15: status bit 31 shows lookup engine request
// R16: status bit 30 shows trigger/timestamp request
// R17: mask bits 31, 30, zero enables
// R18: reserved reads zero, read-only writes ignored
module switch_global_regs #(
   parameter logic [7:0] IDENT_ZERO = 8'h11,  // arbitrary value
   parameter logic [7:0] IDENT_HIGH = 8'h22,  // arbitrary value
   parameter logic [7:0] IDENT_LOW  = 8'h33,  // arbitrary value
   parameter logic [3:0] REVISION   = 4'h1    // arbitrary value
) (
   // clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        sys_rst_i,
   // byte access port from the management front end
   input  wire logic        acc_req_i,
   input  wire logic        acc_we_i,
   input  wire logic        acc_phy_path_i,
   input  wire logic [15:0] acc_addr_i,
   input  wire logic [7:0]  acc_wdata_i,
   output logic             acc_ack_o,
   output logic [7:0]       acc_rdata_o,
   // forwarded access to the other register pages
   output logic             fwd_req_o,
   output logic             fwd_we_o,
   output logic [3:0]       fwd_port_o,
   output logic [3:0]       fwd_page_o,
   output logic [7:0]       fwd_offset_o,
   output logic [7:0]       fwd_wdata_o,
   input  wire logic        fwd_ack_i,
   input  wire logic [7:0]  fwd_rdata_i,
   // event sources
   input  wire logic        lookup_engine_irq_i,
   input  wire logic        time_unit_irq_i,
   input  wire logic        power_event_i,
   // controls toward the switch
   output logic             soft_reset_o,
   output logic             irq_pending_o,
   output logic             power_event_pin_o,
   output logic             power_event_pin_oe_o
);

   // decoded address fields
   logic [3:0]  dec_port;
   logic [3:0]  dec_page;
   logic [7:0]  dec_offset;
   logic        dec_local;
   logic        dec_fwd;

   // access sequencer
   switch_regs_pkg::acc_state_type state_ff, nxt_state;
   logic        ack_ff,    nxt_ack;
   logic [7:0]  rdata_ff,  nxt_rdata;
   logic        fwd_req_ff, nxt_fwd_req;
   logic        fwd_we_ff,  nxt_fwd_we;
   logic [3:0]  fwd_port_ff, nxt_fwd_port;
   logic [3:0]  fwd_page_ff, nxt_fwd_page;
   logic [7:0]  fwd_off_ff,  nxt_fwd_off;
   logic [7:0]  fwd_wd_ff,   nxt_fwd_wd;

   // control registers
   logic        soft_rst_ff, nxt_soft_rst;
   logic [1:0]  pwr_ctl_ff,  nxt_pwr_ctl;   // [1] enable, [0] polarity
   logic [1:0]  irq_mask_ff, nxt_irq_mask;  // [1] lookup, [0] time unit

   // derived outputs
   logic        irq_pend_ff, nxt_irq_pend;
   logic        pin_ff,      nxt_pin;
   logic        pin_oe_ff,   nxt_pin_oe;

   // live status word
   logic [31:0] stat_word;
   logic [31:0] mask_word;
   logic        wr_local;

   // picks one byte of a 32-bit word, lowest address is the top byte
   function automatic logic [7:0] be_byte(input logic [31:0] word,
                                          input logic [1:0]  lane);
      logic [7:0] b;
      unique case (lane)
         2'h0:    b = word[31:24];  // [R5]
         2'h1:    b = word[23:16];  // [R5]
         2'h2:    b = word[15:8];   // [R5]
         2'h3:    b = word[7:0];    // [R5]
      endcase
      return b;
   endfunction

   // address decode and page classification
   reg_addr_decoder u_decoder (
      .addr_i     (acc_addr_i),
      .phy_path_i (acc_phy_path_i),
      .port_o     (dec_port),
      .page_o     (dec_page),
      .offset_o   (dec_offset),
      .local_o    (dec_local),
      .fwd_o      (dec_fwd)
   );

   // status is live level of the sources
   always_comb begin
      stat_word = '0;  // [R18]
      stat_word[switch_regs_pkg::IRQ_LOOKUP_BIT] = lookup_engine_irq_i;  // [R15]
      stat_word[switch_regs_pkg::IRQ_TIME_BIT]   = time_unit_irq_i;      // [R16]
      mask_word = '0;  // [R18]
      mask_word[switch_regs_pkg::IRQ_LOOKUP_BIT] = irq_mask_ff[1];
      mask_word[switch_regs_pkg::IRQ_TIME_BIT]   = irq_mask_ff[0];
   end

   assign wr_local = (state_ff == switch_regs_pkg::ST_IDLE) && acc_req_i
                   && acc_we_i && dec_local;

   // access sequencer next state
   always_comb begin
      nxt_state    = state_ff;
      nxt_ack      = 1'b0;
      nxt_rdata    = rdata_ff;
      nxt_fwd_req  = 1'b0;
      nxt_fwd_we   = fwd_we_ff;
      nxt_fwd_port = fwd_port_ff;
      nxt_fwd_page = fwd_page_ff;
      nxt_fwd_off  = fwd_off_ff;
      nxt_fwd_wd   = fwd_wd_ff;
      unique case (state_ff)
         switch_regs_pkg::ST_IDLE: begin
            if (acc_req_i && dec_fwd) begin
               // other page: hand the byte on and wait
               nxt_state    = switch_regs_pkg::ST_FWD;  // [R6]
               nxt_fwd_req  = 1'b1;
               nxt_fwd_we   = acc_we_i;
               nxt_fwd_port = dec_port;
               nxt_fwd_page = dec_page;
               nxt_fwd_off  = dec_offset;
               nxt_fwd_wd   = acc_wdata_i;
            end else if (acc_req_i) begin
               // local or reserved: answer next cycle
               nxt_ack   = 1'b1;
               nxt_rdata = switch_regs_pkg::ZERO_BYTE;  // [R18]
               if (dec_local && !acc_we_i) begin
                  unique case (dec_offset)
                     switch_regs_pkg::OFF_IDENT_ZERO: nxt_rdata = IDENT_ZERO;
                     switch_regs_pkg::OFF_IDENT_HIGH: nxt_rdata = IDENT_HIGH;
                     switch_regs_pkg::OFF_IDENT_LOW:  nxt_rdata = IDENT_LOW;
                     switch_regs_pkg::OFF_REV_RST: begin
                        nxt_rdata = {REVISION, 3'h0, soft_rst_ff};  // [R18]
                     end
                     switch_regs_pkg::OFF_PWR_EVT: begin
                        nxt_rdata = {6'h00, pwr_ctl_ff};  // [R18]
                     end
                     default: begin
                        // byte lanes of the two 32-bit words
                        if (dec_offset[7:2] == switch_regs_pkg::WORD_IRQ_STAT) begin
                           nxt_rdata = be_byte(stat_word, dec_offset[1:0]);  // [R4]
                        end else if (dec_offset[7:2] == switch_regs_pkg::WORD_IRQ_MASK) begin
                           nxt_rdata = be_byte(mask_word, dec_offset[1:0]);  // [R4]
                        end else begin
                           nxt_rdata = switch_regs_pkg::ZERO_BYTE;  // [R18]
                        end
                     end
                  endcase
               end
            end
         end
         switch_regs_pkg::ST_FWD: begin
            // wait for the page owner to answer
            if (fwd_ack_i) begin
               nxt_state = switch_regs_pkg::ST_IDLE;
               nxt_ack   = 1'b1;
               nxt_rdata = fwd_we_ff ? switch_regs_pkg::ZERO_BYTE : fwd_rdata_i;
            end
         end
      endcase
   end

   // control register writes, single bytes only
   always_comb begin
      nxt_soft_rst = soft_rst_ff;
      nxt_pwr_ctl  = pwr_ctl_ff;
      nxt_irq_mask = irq_mask_ff;
      if (wr_local) begin
         if (dec_offset == switch_regs_pkg::OFF_REV_RST) begin
            // only bit 0 writable, stays until software clears
            nxt_soft_rst = acc_wdata_i[switch_regs_pkg::SOFT_RST_BIT];  // [R12] [R18]
         end else if (dec_offset == switch_regs_pkg::OFF_PWR_EVT) begin
            nxt_pwr_ctl = {acc_wdata_i[switch_regs_pkg::PWR_EN_BIT],
                           acc_wdata_i[switch_regs_pkg::PWR_POL_BIT]};  // [R13] [R14]
         end else if (dec_offset == switch_regs_pkg::OFF_IRQ_MASK) begin
            // top byte of mask word holds both bits
            nxt_irq_mask = acc_wdata_i[7:6];  // [R17] [R5] [R4]
         end
      end
   end

   // derived outputs: masked request and power event pin
   always_comb begin
      nxt_irq_pend = (lookup_engine_irq_i && !irq_mask_ff[1])
                   || (time_unit_irq_i && !irq_mask_ff[0]);  // [R17]
      nxt_pin_oe   = pwr_ctl_ff[1];  // [R13]
      // asserted level follows polarity bit
      nxt_pin      = power_event_i ? pwr_ctl_ff[0] : !pwr_ctl_ff[0];  // [R14]
   end

   // register all state
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_ff    <= switch_regs_pkg::ST_IDLE;
         ack_ff      <= 1'b0;
         rdata_ff    <= switch_regs_pkg::ZERO_BYTE;
         fwd_req_ff  <= 1'b0;
         fwd_we_ff   <= 1'b0;
         fwd_port_ff <= 4'h0;
         fwd_page_ff <= 4'h0;
         fwd_off_ff  <= switch_regs_pkg::ZERO_BYTE;
         fwd_wd_ff   <= switch_regs_pkg::ZERO_BYTE;
         soft_rst_ff <= switch_regs_pkg::SOFT_RST_RST;  // [R12]
         pwr_ctl_ff  <= switch_regs_pkg::PWR_CTL_RST;   // [R13] [R14]
         irq_mask_ff <= switch_regs_pkg::IRQ_MASK_RST;  // [R17]
         irq_pend_ff <= 1'b0;
         pin_ff      <= 1'b1;
         pin_oe_ff   <= 1'b0;
      end else begin
         state_ff    <= nxt_state;
         ack_ff      <= nxt_ack;
         rdata_ff    <= nxt_rdata;
         fwd_req_ff  <= nxt_fwd_req;
         fwd_we_ff   <= nxt_fwd_we;
         fwd_port_ff <= nxt_fwd_port;
         fwd_page_ff <= nxt_fwd_page;
         fwd_off_ff  <= nxt_fwd_off;
         fwd_wd_ff   <= nxt_fwd_wd;
         soft_rst_ff <= nxt_soft_rst;
         pwr_ctl_ff  <= nxt_pwr_ctl;
         irq_mask_ff <= nxt_irq_mask;
         irq_pend_ff <= nxt_irq_pend;
         pin_ff      <= nxt_pin;
         pin_oe_ff   <= nxt_pin_oe;
      end
   end

   // output mapping
   assign acc_ack_o            = ack_ff;
   assign acc_rdata_o          = rdata_ff;
   assign fwd_req_o            = fwd_req_ff;
   assign fwd_we_o             = fwd_we_ff;
   assign fwd_port_o           = fwd_port_ff;
   assign fwd_page_o           = fwd_page_ff;
   assign fwd_offset_o         = fwd_off_ff;
   assign fwd_wdata_o          = fwd_wd_ff;
   assign soft_reset_o         = soft_rst_ff;  // [R12]
   assign irq_pending_o        = irq_pend_ff;
   assign power_event_pin_o    = pin_ff;
   assign power_event_pin_oe_o = pin_oe_ff;

endmodule

// ### switch_regs_monitor.sv
module switch_regs_monitor (
   // clock and reset
   input wire logic        core_clk_i,
   input wire logic        sys_rst_i,
   // access port
   input wire logic        acc_phy_path_i,
   input wire logic [15:0] acc_addr_i,
   input wire logic        acc_ack_o,
   input wire logic [7:0]  acc_rdata_o,
   // forward port
   input wire logic        fwd_req_o,
   input wire logic [3:0]  fwd_port_o,
   input wire logic [3:0]  fwd_page_o,
   input wire logic [7:0]  fwd_offset_o,
   input wire logic        fwd_ack_i,
   // events and controls
   input wire logic        lookup_engine_irq_i,
   input wire logic        time_unit_irq_i,
   input wire logic        soft_reset_o,
   input wire logic        irq_pending_o,
   input wire logic        power_event_pin_oe_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);
   logic pend_ff;  // forward outstanding
   logic nxt_pend; // next outstanding flag
   // forward stays open until the owner answers
   always_comb nxt_pend = fwd_req_o | (pend_ff & ~fwd_ack_i);
   // register the flag
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) pend_ff <= 1'b0;
      else pend_ff <= nxt_pend;
   end
   a_fwd_fields: assert property (
      fwd_req_o |-> {fwd_port_o, fwd_page_o, fwd_offset_o} == $past(acc_addr_i))
      else $error("forward fields differ from address");
   a_fwd_legal: assert property (
      fwd_req_o |-> ((fwd_port_o == 4'h0) ? (fwd_page_o inside {[4'h1:4'h5]})
         : (fwd_port_o <= 4'h7 && !(fwd_page_o inside {4'h2, 4'h7, [4'hd:4'hf]}))))
      else $error("reserved page forwarded");
   a_phy_only: assert property (
      fwd_req_o && $past(acc_phy_path_i) |-> fwd_page_o == 4'h1 && fwd_port_o != 4'h0)
      else $error("phy path reached a switch page");
   a_fwd_answer: assert property (
      fwd_ack_i && pend_ff |=> acc_ack_o)
      else $error("forward answer not passed on");
   a_ack_pulse: assert property (
      acc_ack_o |=> !acc_ack_o)
      else $error("ack longer than one cycle");
   a_rdata_hold: assert property (
      !acc_ack_o |-> $stable(acc_rdata_o))
      else $error("read data moved without ack");
   a_irq_quiet: assert property (
      !$past(lookup_engine_irq_i) && !$past(time_unit_irq_i) |-> !irq_pending_o)
      else $error("pending without a source");
   a_srst_cause: assert property (
      $changed(soft_reset_o) |-> acc_ack_o || $past(acc_ack_o))
      else $error("soft reset moved without a write");
   a_oe_cause: assert property (
      $changed(power_event_pin_oe_o) |-> $past(acc_ack_o))
      else $error("pin enable moved without a write");
endmodule

bind switch_global_regs switch_regs_monitor mon (
   .core_clk_i, .sys_rst_i, .acc_phy_path_i, .acc_addr_i, .acc_ack_o, .acc_rdata_o,
   .fwd_req_o, .fwd_port_o, .fwd_page_o, .fwd_offset_o, .fwd_ack_i,
   .lookup_engine_irq_i, .time_unit_irq_i, .soft_reset_o, .irq_pending_o,
   .power_event_pin_oe_o);

// ### switch_regs_pkg.sv
package switch_regs_pkg;

   // address field layout
   localparam int ADDR_W        = 16;
   localparam int PORT_MSB      = 15;
   localparam int PORT_LSB      = 12;
   localparam int PAGE_MSB      = 11;
   localparam int PAGE_LSB      = 8;
   localparam int OFFS_MSB      = 7;
   localparam int OFFS_LSB      = 0;

   // port field values
   localparam logic [3:0] PORT_GLOBAL   = 4'h0;
   localparam logic [3:0] PORT_LAST     = 4'h7;

   // global page numbers
   localparam logic [3:0] GPAGE_OPER    = 4'h0;
   localparam logic [3:0] GPAGE_LAST    = 4'h5;

   // per-port page numbers
   localparam logic [3:0] PPAGE_PHY     = 4'h1;
   localparam logic [3:0] PPAGE_RSV_A   = 4'h2;
   localparam logic [3:0] PPAGE_RSV_B   = 4'h7;
   localparam logic [3:0] PPAGE_LAST    = 4'hc;

   // global operation page offsets
   localparam logic [7:0] OFF_IDENT_ZERO = 8'h00;
   localparam logic [7:0] OFF_IDENT_HIGH = 8'h01;
   localparam logic [7:0] OFF_IDENT_LOW  = 8'h02;
   localparam logic [7:0] OFF_REV_RST    = 8'h03;
   localparam logic [7:0] OFF_PWR_EVT    = 8'h06;
   localparam logic [7:0] OFF_IRQ_STAT   = 8'h10;
   localparam logic [7:0] OFF_IRQ_MASK   = 8'h14;
   localparam logic [5:0] WORD_IRQ_STAT  = 6'h04;
   localparam logic [5:0] WORD_IRQ_MASK  = 6'h05;

   // field positions
   localparam int SOFT_RST_BIT   = 0;
   localparam int PWR_EN_BIT     = 1;
   localparam int PWR_POL_BIT    = 0;
   localparam int IRQ_LOOKUP_BIT = 31;
   localparam int IRQ_TIME_BIT   = 30;
   localparam int REV_LSB        = 4;

   // reset values
   localparam logic       SOFT_RST_RST = 1'b0;
   localparam logic [1:0] PWR_CTL_RST  = 2'h0;
   localparam logic [1:0] IRQ_MASK_RST = 2'h0;
   localparam logic [7:0] ZERO_BYTE    = 8'h00;

   // access sequencer states
   typedef enum logic [0:0] {
      ST_IDLE,
      ST_FWD
   } acc_state_type;

endpackage

// ### tb_switch_global_register_map.sv
module tb_switch_global_register_map;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk_i, sys_rst_i, acc_req_i, acc_we_i, acc_phy_path_i;
   logic lookup_engine_irq_i, time_unit_irq_i, power_event_i;
   logic [15:0] acc_addr_i;
   logic [7:0]  acc_wdata_i, acc_rdata_o, fwd_offset_o, fwd_rdata_i;
   logic [3:0]  fwd_port_o, fwd_page_o;
   logic acc_ack_o, fwd_req_o, fwd_ack_i, soft_reset_o, irq_pending_o;
   logic power_event_pin_o, power_event_pin_oe_o;
   logic [7:0] exp_q[$];  // expected read bytes in order
   logic fwd_we_o;                   // forwarded write flag
   logic [7:0] fwd_wdata_o, wd;      // forwarded write byte, byte sent
   logic [24:0] fwd_q[$], fwd_seen;  // expected forwards {we, port, page, offset, data}
   int err_count, n_compared;
   logic [7:0] rv [8] = '{8'h11, 8'h22, 8'h33, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [7:0] o, d;
   logic ok, w, ph;

   switch_global_regs #(.IDENT_ZERO(8'h11), .IDENT_HIGH(8'h22), .IDENT_LOW(8'h33),
      .REVISION(4'h1)) dut (
      .core_clk_i, .sys_rst_i, .acc_req_i, .acc_we_i, .acc_phy_path_i, .acc_addr_i,
      .acc_wdata_i, .acc_ack_o, .acc_rdata_o, .fwd_req_o, .fwd_we_o, .fwd_port_o,
      .fwd_page_o, .fwd_offset_o, .fwd_wdata_o, .fwd_ack_i, .fwd_rdata_i,
      .lookup_engine_irq_i, .time_unit_irq_i, .power_event_i, .soft_reset_o,
      .irq_pending_o, .power_event_pin_o, .power_event_pin_oe_o);
   page_owner_model owner (.core_clk_i, .fwd_req_i(fwd_req_o), .offset_i(fwd_offset_o),
      .ack_o(fwd_ack_i), .rdata_o(fwd_rdata_i));

   // clock
   initial begin
      core_clk_i = 1'b0;
      forever #2 core_clk_i = ~core_clk_i;
   end

   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cmp_fwd(input logic [24:0] got, input logic [24:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t forward got %h expected %h", $time, got, exp);
      end
   endtask

   // one byte access; the note goes on the queue before the request
   task automatic acc(input logic wr, input logic p, input logic [15:0] a,
                      input logic [7:0] dat, input logic [7:0] e);
      int n;
      exp_q.push_back(wr ? 8'h00 : e);
      @(negedge core_clk_i);
      {acc_req_i, acc_we_i, acc_phy_path_i, acc_addr_i, acc_wdata_i} = {1'b1, wr, p, a, dat};
      @(negedge core_clk_i);
      acc_req_i = 1'b0;
      n = 0;
      while (acc_ack_o !== 1'b1 && n < 20) begin
         @(negedge core_clk_i);
         n++;
      end
      if (acc_ack_o !== 1'b1) begin
         err_count++;
         $display("[ERR] %0t no ack", $time);
         wrap_up();
      end
   endtask

   // watcher: each ack takes the oldest note
   always @(negedge core_clk_i) if (acc_ack_o === 1'b1) begin
      if (exp_q.size() == 0) begin
         err_count++;
         $display("[ERR] %0t unexpected ack", $time);
      end else cmp(acc_rdata_o, exp_q.pop_front());
   end

   // forward watcher: each forward pulse takes the oldest forward note
   assign fwd_seen = {fwd_we_o, fwd_port_o, fwd_page_o, fwd_offset_o, fwd_wdata_o};
   always @(negedge core_clk_i) if (fwd_req_o === 1'b1) begin
      if (fwd_q.size() == 0) begin
         err_count++;
         $display("[ERR] %0t unexpected forward", $time);
      end else cmp_fwd(fwd_seen, fwd_q.pop_front());
   end

   // watchdog
   initial begin
      #100000;
      err_count++;
      $display("[ERR] %0t run too long", $time);
      wrap_up();
   end

   initial begin
      {acc_req_i, acc_we_i, acc_phy_path_i, lookup_engine_irq_i} = 4'h0;
      {time_unit_irq_i, power_event_i, acc_addr_i, acc_wdata_i} = '0;
      sys_rst_i = 1'b1;
      void'($urandom(1309));
      repeat (6) @(posedge core_clk_i);
      @(negedge core_clk_i) sys_rst_i = 1'b0;
      acc(0, 0, 16'h0006, 8'h00, 8'h00);
      // read-only and unlisted bytes ignore writes
      for (int a = 0; a < 8; a++) if (a != 6) begin
         acc(1, 0, 16'(a), 8'($urandom) & 8'hfe, 8'h00);
         acc(0, 0, 16'(a), 8'h00, rv[a]);
      end
      // every enable and polarity code, event idle and active
      for (int m = 0; m < 4; m++) begin
         acc(1, 0, 16'h0006, {6'($urandom), 2'(m)}, 8'h00);
         acc(0, 0, 16'h0006, 8'h00, 8'(m));
         for (int ev = 0; ev < 2; ev++) begin
            power_event_i = 1'(ev);
            repeat (3) @(negedge core_clk_i);
            ok = (ev == 1) ? m[0] : ~m[0];
            cmp({6'h00, power_event_pin_oe_o, power_event_pin_o}, {6'h00, m[1], ok});
         end
      end
      // soft reset stays set and keeps register contents
      acc(1, 0, 16'h0003, rv[3] | 8'h01, 8'h00);
      repeat (2) @(negedge core_clk_i);
      cmp({7'h00, soft_reset_o}, 8'h01);
      acc(0, 0, 16'h0003, 8'h00, 8'h11);
      acc(0, 0, 16'h0006, 8'h00, 8'h03);
      acc(1, 0, 16'h0003, rv[3], 8'h00);
      repeat (2) @(negedge core_clk_i);
      cmp({7'h00, soft_reset_o}, 8'h00);
      // status sources against mask bits, big-endian bytes
      for (int i = 0; i < 16; i++) begin
         {time_unit_irq_i, lookup_engine_irq_i} = 2'(i);
         acc(1, 0, 16'h0014, {2'(i >> 2), 6'h00}, 8'h00);
         acc(0, 0, 16'h0010, 8'h00, {lookup_engine_irq_i, time_unit_irq_i, 6'h00});
         acc(0, 0, 16'h0013, 8'h00, 8'h00);
         acc(0, 0, 16'h0014, 8'h00, {2'(i >> 2), 6'h00});
         ok = (lookup_engine_irq_i & ~i[3]) | (time_unit_irq_i & ~i[2]);
         cmp({7'h00, irq_pending_o}, {7'h00, ok});
      end
      // every port and page except port 0 page 0, legal ones forwarded, writes only where legal
      for (int p = 0; p < 8; p++) for (int pg = 0; pg < 16; pg++) if (p + pg > 0) begin
         ok = (p == 0) ? (pg >= 1 && pg <= 5) : (p <= 7 && !(pg inside {2, 7, [13:15]}));
         ph = 1'($urandom);
         if (ph && !(p >= 1 && p <= 7 && pg == 1)) ok = 1'b0;
         w = ok & 1'($urandom);
         o = 8'($urandom);
         wd = 8'($urandom);
         d = ok ? (o ^ 8'h5a) : 8'h00;
         if (ok) fwd_q.push_back({w, 4'(p), 4'(pg), o, wd});
         acc(w, ph, {4'(p), 4'(pg), o}, wd, d);
      end
      acc(0, 1, 16'h0001, 8'h00, 8'h00);
      // phy path write to a switch register is dropped
      acc(1, 1, 16'h0006, 8'h00, 8'h00);
      acc(0, 0, 16'h0006, 8'h00, 8'h03);
      repeat (4) @(negedge core_clk_i);
      cmp(8'(exp_q.size()), 8'h00);
      cmp(8'(fwd_q.size()), 8'h00);
      wrap_up();
   end
endmodule
